// ### adcsq_cfg.svh
// Register offsets, field positions, reset values and timing counts of the sequencer
`ifndef ADCSQ_CFG_SVH
`define ADCSQ_CFG_SVH

// ==========================================================================
// Register map (byte addresses, one aligned word each)
`define ADCSQ_OFF_CTRL      8'h00
`define ADCSQ_OFF_SLOT1     8'h04
`define ADCSQ_OFF_SLOT2     8'h08
`define ADCSQ_OFF_SLOT3     8'h0c
`define ADCSQ_OFF_SLOT4     8'h10
`define ADCSQ_OFF_STATUS    8'h14

// ==========================================================================
// Control/status fields
`define ADCSQ_BIT_DONE      7
`define ADCSQ_BIT_ZERO      6
`define ADCSQ_BIT_SCAN      5
`define ADCSQ_BIT_GROUP     4
`define ADCSQ_CTRL_RESET    8'h00

// ==========================================================================
// Conversion timing in system clocks
`define ADCSQ_SAMPLE_CYC    12
`define ADCSQ_BITS          8

`endif

// ### adcsq_pkg.sv
// Types shared by the converter sequencer
`default_nettype none
package adcsq_pkg;
    typedef enum logic [2:0] {
        ADCSQ_IDLE   = 3'b001,
        ADCSQ_SAMPLE = 3'b010,
        ADCSQ_CMP    = 3'b100
    } adcsq_state_t;

    typedef enum logic [1:0] {
        ADCSQ_RESP_OKAY   = 2'b00,
        ADCSQ_RESP_SLVERR = 2'b10
    } adcsq_resp_t;
endpackage
`default_nettype wire

// ### adcsq_sar.sv
// One successive-approximation conversion: sample phase then eight compares
`include "adcsq_cfg.svh"
`default_nettype none
module adcsq_sar #(
    parameter int SAMPLE_CYC = `ADCSQ_SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control
    input  wire logic        start,
    input  wire logic        abort,
    input  wire logic        hold,
    // Analog front end
    output logic             sampleGate,
    output logic [7:0]       dacCode,
    input  wire logic        cmpHigh,
    // Result
    output logic             done,
    output logic [7:0]       result
);
    import adcsq_pkg::*;

    adcsq_state_t  state_q, state_d;
    logic [4:0]    cnt_q, cnt_d;
    logic [2:0]    bitIdx_q, bitIdx_d;
    logic [7:0]    sar_q, sar_d;
    logic [7:0]    result_q;
    logic          done_q;

    wire logic [7:0] trialBit = 8'h01 << bitIdx_q;
    wire logic       lastCmp  = (bitIdx_q == 3'h0);

    assign sampleGate = (state_q == ADCSQ_SAMPLE);
    assign dacCode    = sar_q | trialBit;
    assign done       = done_q;
    assign result     = result_q;

    // ==========================================================================
    // Step control; a hold drops back to sampling so the channel is resampled
    always_comb begin
        state_d  = state_q;
        cnt_d    = cnt_q;
        bitIdx_d = bitIdx_q;
        sar_d    = sar_q;
        if (abort) begin
            state_d = ADCSQ_IDLE;
        end else if (hold) begin
            // A start pulse that meets a hold is parked in sampling, not lost
            if (state_q != ADCSQ_IDLE || start) begin
                state_d = ADCSQ_SAMPLE;
                cnt_d   = 5'h00;
            end
        end else begin
            unique case (state_q)
                ADCSQ_IDLE: begin
                    if (start) begin
                        state_d = ADCSQ_SAMPLE;
                        cnt_d   = 5'h00;
                    end
                end
                ADCSQ_SAMPLE: begin
                    cnt_d = cnt_q + 5'h01;
                    if (cnt_q == 5'(SAMPLE_CYC - 1)) begin
                        state_d  = ADCSQ_CMP;
                        bitIdx_d = 3'h7;
                        sar_d    = 8'h00;
                    end
                end
                ADCSQ_CMP: begin
                    sar_d    = cmpHigh ? (sar_q | trialBit) : sar_q;
                    bitIdx_d = bitIdx_q - 3'h1;
                    if (lastCmp) begin
                        state_d = ADCSQ_IDLE;
                    end
                end
            endcase
        end
    end

    wire logic finish = !abort && !hold && (state_q == ADCSQ_CMP) && lastCmp;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q  <= ADCSQ_IDLE;
            cnt_q    <= 5'h00;
            bitIdx_q <= 3'h7;
            sar_q    <= 8'h00;
            result_q <= 8'h00;
            done_q   <= 1'b0;
        end else begin
            state_q  <= state_d;
            cnt_q    <= cnt_d;
            bitIdx_q <= bitIdx_d;
            sar_q    <= sar_d;
            done_q   <= finish;
            if (finish) begin
                result_q <= sar_d;
            end
        end
    end
endmodule
`default_nettype wire

// ### adcsq_top.sv
// Converter sequencer: AXI4-Lite register file, channel steering, result slots
//
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`include "adcsq_cfg.svh"
`default_nettype none
module adcsq_top #(
    parameter int SAMPLE_CYC = `ADCSQ_SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // AXI4-Lite write address
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    // AXI4-Lite write data
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output adcsq_pkg::adcsq_resp_t s_axi_bresp,
    // AXI4-Lite read address
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    // AXI4-Lite read data
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output adcsq_pkg::adcsq_resp_t s_axi_rresp,
    // Power modes
    input  wire logic        lowPowerHold,
    // Analog front end
    output logic [3:0]       muxSelect,
    output logic             sampleGate,
    output logic [7:0]       dacCode,
    input  wire logic        cmpHigh
);
    import adcsq_pkg::*;

    // ==========================================================================
    // Write channel: address and data captured independently, in either order
    logic        awHeld_q, wHeld_q, bvalid_q;
    logic [7:0]  awAddr_q;
    logic [7:0]  wData_q;
    logic        wLane0_q;
    adcsq_resp_t bresp_q;

    assign s_axi_awready = !awHeld_q && !bvalid_q;
    assign s_axi_wready  = !wHeld_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    wire logic doWrite    = awHeld_q && wHeld_q && !bvalid_q;
    wire logic wrCtrlHit  = (awAddr_q == `ADCSQ_OFF_CTRL);
    wire logic wrKnown    = isMapped(awAddr_q);
    wire logic ctrlWrite  = doWrite && wrCtrlHit && wLane0_q;

    function automatic logic isMapped(input logic [7:0] addr);
        isMapped = (addr == `ADCSQ_OFF_CTRL)  || (addr == `ADCSQ_OFF_SLOT1) ||
                   (addr == `ADCSQ_OFF_SLOT2) || (addr == `ADCSQ_OFF_SLOT3) ||
                   (addr == `ADCSQ_OFF_SLOT4) || (addr == `ADCSQ_OFF_STATUS);
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q  <= 8'h00;
            wLane0_q <= 1'b0;
            bresp_q  <= ADCSQ_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q  <= 1'b1;
                wData_q  <= s_axi_wdata[7:0];
                wLane0_q <= s_axi_wstrb[0];
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
                bvalid_q <= 1'b1;
                // Slot writes are accepted and dropped
                bresp_q  <= wrKnown ? ADCSQ_RESP_OKAY : ADCSQ_RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ==========================================================================
    // Control register and sequencer state
    logic       scan_q, group_q, done_q;
    logic [3:0] sel_q;
    logic       running_q, startPend_q;
    logic [1:0] slotIdx_q;
    logic [7:0] slot_q [4];

    logic       convDone;
    logic [7:0] convResult;

    wire logic [7:0] ctrlRead = {done_q, 1'b0, scan_q, group_q, sel_q};

    // Group mode overrides the low select bits with the slot position
    assign muxSelect = group_q ? {sel_q[3:2], slotIdx_q} : sel_q;

    wire logic lastSlot = (slotIdx_q == 2'h3);
    wire logic kickConv = startPend_q || (convDone && running_q && !(lastSlot && !scan_q));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            scan_q      <= 1'b0;
            group_q     <= 1'b0;
            sel_q       <= 4'h0;
            done_q      <= 1'b0;
            running_q   <= 1'b0;
            startPend_q <= 1'b0;
            slotIdx_q   <= 2'h0;
        end else begin
            startPend_q <= 1'b0;
            if (ctrlWrite) begin
                scan_q      <= wData_q[`ADCSQ_BIT_SCAN];
                group_q     <= wData_q[`ADCSQ_BIT_GROUP];
                sel_q       <= wData_q[3:0];
                done_q      <= 1'b0;
                running_q   <= 1'b1;
                startPend_q <= 1'b1;
                slotIdx_q   <= 2'h0;
            end else if (convDone && running_q) begin
                slotIdx_q <= slotIdx_q + 2'h1;
                if (lastSlot) begin
                    done_q <= 1'b1;
                    if (!scan_q) begin
                        running_q <= 1'b0;
                    end
                end
            end
        end
    end

    // Whole byte lands only on completion of its own conversion
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                slot_q[i] <= 8'h00;
            end
        end else if (convDone && running_q && !ctrlWrite) begin
            slot_q[slotIdx_q] <= convResult;
        end
    end

    // Hold keeps the step machine parked and forces a resample on release
    adcsq_sar #(
        .SAMPLE_CYC (SAMPLE_CYC)
    ) u_sar (
        .clk        (clk),
        .rst_n      (rst_n),
        .start      (kickConv && !ctrlWrite),
        .abort      (ctrlWrite),
        .hold       (lowPowerHold),
        .sampleGate (sampleGate),
        .dacCode    (dacCode),
        .cmpHigh    (cmpHigh),
        .done       (convDone),
        .result     (convResult)
    );

    // ==========================================================================
    // Read channel
    logic        rvalid_q;
    logic [31:0] rdata_q;
    adcsq_resp_t rresp_q;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

    wire logic [7:0] statusRead = {5'h00, running_q, slotIdx_q};

    function automatic logic [7:0] readMux(input logic [7:0] addr, input logic [7:0] ctrl,
                                           input logic [7:0] stat);
        readMux = 8'h00;
        if (addr == `ADCSQ_OFF_CTRL) readMux = ctrl;
        if (addr == `ADCSQ_OFF_SLOT1) readMux = slot_q[0];
        if (addr == `ADCSQ_OFF_SLOT2) readMux = slot_q[1];
        if (addr == `ADCSQ_OFF_SLOT3) readMux = slot_q[2];
        if (addr == `ADCSQ_OFF_SLOT4) readMux = slot_q[3];
        if (addr == `ADCSQ_OFF_STATUS) readMux = stat;
    endfunction

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= ADCSQ_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, readMux(s_axi_araddr, ctrlRead, statusRead)};
            rresp_q  <= isMapped(s_axi_araddr) ? ADCSQ_RESP_OKAY : ADCSQ_RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### adcsq_top_properties.sv
// Concurrent checks on the sequencer register bus and front end
`default_nettype none
module adcsq_top_properties
    import adcsq_pkg::*;
#(
    parameter int SAMPLE_CYC = 12
) (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire adcsq_pkg::adcsq_resp_t s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire adcsq_pkg::adcsq_resp_t s_axi_rresp,
    // Power and analog front end
    input wire logic        lowPowerHold,
    input wire logic [3:0]  muxSelect,
    input wire logic        sampleGate,
    input wire logic [7:0]  dacCode,
    input wire logic        cmpHigh
);
    timeunit 1ns;
    timeprecision 1ns;
    // ======================================================================
    // Address of the read in flight
    logic [7:0] rdAddr_q;
    always_ff @(posedge clk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rdAddr_q <= s_axi_araddr;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence wrBoth;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ctrlWr;
        wrBoth ##0 (s_axi_awaddr == 8'h00 && s_axi_wstrb[0]);
    endsequence

    // ======================================================================
    // Properties
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rvalid_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    a_write_answer: assert property (wrBoth |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_ctrl_bit6: assert property (s_axi_rvalid && rdAddr_q == 8'h00 |->
        !s_axi_rdata[6] && s_axi_rdata[31:8] == 24'h0) else $error("control bit 6 set");
    a_unmapped_err: assert property (s_axi_rvalid && rdAddr_q > 8'h14 |->
        s_axi_rresp == ADCSQ_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad unmapped");
    a_seq_start: assert property (ctrlWr ##0 !lowPowerHold |-> ##[2:4] sampleGate)
        else $error("sequence did not start");
endmodule
bind adcsq_top adcsq_top_properties #(.SAMPLE_CYC(SAMPLE_CYC)) adcsq_top_properties_inst (.*);
`default_nettype wire

// ### adcsq_top_tb_top.sv
// Self-checking bench for the converter sequencer
`include "adcsq_cfg.svh"
`default_nettype none
module adcsq_top_tb_top
    import adcsq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, hold = 1'b0, cmpHigh;
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic awReady, wReady, bValid, arReady, rValid, sampleGate;
    logic [7:0] awAddr = 8'h00, arAddr = 8'h00, dacCode, c;
    logic [3:0] muxSel;
    logic [31:0] wData = 32'h0, rData, d;
    adcsq_resp_t bResp, rResp, r;
    logic [7:0] vin [16];
    int seed = 84;
    int failCount = 0;
    int samplesChecked = 0;

    always #25 clk = ~clk;
    // Half-LSB offset: an input at vin reads as above any code up to vin
    always_comb cmpHigh = vin[muxSel] >= dacCode;

    adcsq_top #(.SAMPLE_CYC(2)) adcsq_top_inst (.clk(clk), .rst_n(rst_n),
        .s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_awaddr(awAddr),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_wdata(wData),
        .s_axi_wstrb(4'h1), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
        .s_axi_bresp(bResp), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
        .s_axi_araddr(arAddr), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .s_axi_rdata(rData), .s_axi_rresp(rResp), .lowPowerHold(hold),
        .muxSelect(muxSel), .sampleGate(sampleGate), .dacCode(dacCode), .cmpHigh(cmpHigh));

    // ======================================================================
    // Bus tasks: ready is looked at mid-cycle, the transfer lands on the next edge
    task automatic axiWrite(input logic [7:0] a, input logic [31:0] v, output adcsq_resp_t rs);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        awAddr <= a;
        wData <= v;
        awValid <= 1'b1;
        wValid <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && awReady;
            tw = pw && wReady;
            @(posedge clk);
            if (ta) begin
                awValid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                wValid <= 1'b0;
                pw = 1'b0;
            end
        end
        // Ready held back now and then so a standing response is exercised
        if ($random(seed) & 1) repeat (2) @(posedge clk);
        bReady <= 1'b1;
        do begin
            @(negedge clk);
            ta = bValid;
            rs = bResp;
            @(posedge clk);
        end while (!ta);
        bReady <= 1'b0;
    endtask

    task automatic axiRead(input logic [7:0] a, output logic [31:0] v, output adcsq_resp_t rs);
        logic t;
        @(posedge clk);
        arAddr <= a;
        arValid <= 1'b1;
        do begin
            @(negedge clk);
            t = arReady;
            @(posedge clk);
        end while (!t);
        arValid <= 1'b0;
        if ($random(seed) & 1) @(posedge clk);
        rReady <= 1'b1;
        do begin
            @(negedge clk);
            t = rValid;
            v = rData;
            rs = rResp;
            @(posedge clk);
        end while (!t);
        rReady <= 1'b0;
    endtask

    // ======================================================================
    // Checking helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        axiRead(a, d, r);
        check(d, e);
    endtask

    function automatic logic [7:0] expSlot(input logic [7:0] cc, input int k);
        return cc[4] ? vin[{cc[3:2], 2'(k)}] : vin[cc[3:0]];
    endfunction

    task automatic slotsChk(input logic [7:0] cc);
        for (int k = 0; k < 4; k++) begin
            rdChk(8'(4 + 4 * k), {24'h0, expSlot(cc, k)});
        end
    endtask

    task automatic newVin();
        @(posedge clk);
        foreach (vin[j]) vin[j] <= 8'($random(seed));
    endtask

    // Write, optionally suspend mid-conversion with fresh inputs, then wait for the flag
    task automatic runSeq(input logic [7:0] cc, input bit h);
        axiWrite(`ADCSQ_OFF_CTRL, {24'h0, cc}, r);
        rdChk(`ADCSQ_OFF_CTRL, {26'h0, cc[5:0]});
        if (h) begin
            hold <= 1'b1;
            repeat (40) @(posedge clk);
            newVin();
            hold <= 1'b0; // delayed exit: no settling wait needed
        end
        do axiRead(`ADCSQ_OFF_CTRL, d, r); while (d[7] !== 1'b1);
        rdChk(`ADCSQ_OFF_CTRL, {24'h0, 2'b10, cc[5:0]});
        slotsChk(cc);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", samplesChecked, failCount);
        if (failCount == 0 && samplesChecked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        failCount++;
        conclude();
    end

    // ======================================================================
    // Main sequence
    initial begin
        newVin();
        repeat (11) @(posedge clk);
        rst_n <= 1'b1;
        // Control, slots and status all read zero after reset
        for (int k = 0; k < 6; k++) rdChk(8'(4 * k), 32'h0);
        // Every select code once, then random settings; bits 7 and 6 written at random
        for (int i = 0; i < 24; i++) begin
            c = 8'($random(seed));
            c[5] = 1'b0;
            if (i < 16) c[3:0] = 4'(i);
            newVin();
            runSeq(c, i == 20);
        end
        // Abort a running sequence by a second write
        axiWrite(`ADCSQ_OFF_CTRL, 32'h03, r);
        repeat (10) @(posedge clk);
        newVin();
        runSeq(8'h16, 1'b0);
        // Continuous scan, single then group: slots follow new inputs, flag stays set
        for (int s = 0; s < 2; s++) begin
            c = 8'h20 | 8'(s << 4) | 8'($random(seed) & 7);
            runSeq(c, 1'b0);
            newVin();
            repeat (150) @(posedge clk);
            rdChk(`ADCSQ_OFF_CTRL, {24'h0, 2'b10, c[5:0]});
            slotsChk(c);
        end
        axiWrite(`ADCSQ_OFF_SLOT1, 32'h5a, r);
        check({30'h0, r}, {30'h0, ADCSQ_RESP_OKAY});
        rdChk(`ADCSQ_OFF_SLOT1, {24'h0, expSlot(c, 0)});
        axiWrite(8'h40, 32'h11, r);
        check({30'h0, r}, {30'h0, ADCSQ_RESP_SLVERR});
        axiRead(8'h40, d, r);
        check({30'h0, r}, {30'h0, ADCSQ_RESP_SLVERR});
        check(d, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
